// File: two_wire_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side masters and slaves seen through the bit engine: one clock late
module two_wire_bus_peer (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire two_wire_pkg::engine_event_type stim,
  output var two_wire_pkg::engine_event_type  ev
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ev <= '0;
    end else begin
      ev <= stim;
    end
  end
endmodule
`default_nettype wire

// File: two_wire_pkg.sv
// Function
// - Master: transfer-done low during frame, set when buffers empty and STOP sent.
// - Slave: transfer-done clears on START, sets on STOP or foreign repeated address.
// - Receive-ready sets when a byte lands, clears when holding register read.
// - Master: holding write clears tx-ready; shifter load or NACK sets it.
// - Master: master enable command also sets tx-ready.
// - Slave: tx-ready low from holding write until byte acknowledged or NACK seen.
// - Slave-read shows master access direction, meaningful only while addressed.
// - Slave-addressed sets on own address match, clears on NACK or STOP.
// - General-call flag sets on general call, clears on status read.
// - Master overrun sets on reload while full; status read with done clears.
// - Master NACK flag sets with transfer-done; cleared by status read.
// - Slave read: NACK flag sets when master does not acknowledge.
// - Slave write: every received data byte is acknowledged.
// - Arbitration-lost sets with transfer-done; cleared by status read.
// - Slave stretches clock and flags it while holding registers not serviced.
// - End-of-access sets when slave-addressed clears; cleared by status read.
// - Master: count-done flags set when DMA counter reaches zero since write.
// - Master: buffers-exhausted flags set while current and next counters zero.
// - Enable register: writing 1 enables a source, 0 no effect.
// - Disable register: writing 1 disables; mask register reads enabled sources.
// - Sources at bits 0,1,2,4..15; bit 3 and above 15 none.
// - Receive holding register returns last byte in bits 7 to 0.
// - Status slave-read at bit 3, clock-wait at bit 10, reset 0x0000f009.
package two_wire_pkg;
  localparam logic [7:0]  status_reg_off   = 8'h20;
  localparam logic [7:0]  irq_set_off      = 8'h24;
  localparam logic [7:0]  irq_clear_off    = 8'h28;
  localparam logic [7:0]  irq_mask_off     = 8'h2c;
  localparam logic [7:0]  rx_holding_off   = 8'h30;
  localparam logic [7:0]  tx_holding_off   = 8'h34;
  localparam logic [7:0]  control_off      = 8'h00;
  localparam logic [7:0]  rx_dma_cnt_off   = 8'h40;
  localparam logic [7:0]  rx_dma_next_off  = 8'h44;
  localparam logic [7:0]  tx_dma_cnt_off   = 8'h48;
  localparam logic [7:0]  tx_dma_next_off  = 8'h4c;
  localparam int          done_bit         = 0;
  localparam int          rx_full_bit      = 1;
  localparam int          tx_empty_bit     = 2;
  localparam int          slave_read_bit   = 3;
  localparam int          addressed_bit    = 4;
  localparam int          gcall_bit        = 5;
  localparam int          overrun_bit      = 6;
  localparam int          nack_bit         = 8;
  localparam int          arb_bit          = 9;
  localparam int          stretch_bit      = 10;
  localparam int          access_end_bit   = 11;
  localparam int          rx_cnt_done_bit  = 12;
  localparam int          tx_cnt_done_bit  = 13;
  localparam int          rx_exh_bit       = 14;
  localparam int          tx_exh_bit       = 15;
  localparam int          master_en_bit    = 2;
  localparam int          master_dis_bit   = 3;
  localparam int          slave_en_bit     = 4;
  localparam int          slave_dis_bit    = 5;
  localparam logic [31:0] status_reset     = 32'h0000f009;
  localparam logic [31:0] source_bits      = 32'h0000fff7;
  localparam logic [15:0] dma_count_reset  = 16'h0000;

  // Events reported by the bit-level engine, one cycle pulses; frame_active, shifter_empty and char_due are levels
  typedef struct packed {
    logic       start_seen;
    logic       stop_seen;
    logic       stop_sent;
    logic       addr_match;
    logic       addr_miss;
    logic       addr_read;
    logic       gcall_seen;
    logic       byte_rx;
    logic [7:0] rx_data;
    logic       shifter_load;
    logic       byte_acked;
    logic       nack_seen;
    logic       arb_lost;
    logic       char_due;
    logic       frame_active;
    logic       shifter_empty;
  } engine_event_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } reg_req_type;
endpackage

// File: two_wire_status_irq.sv
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module two_wire_status_irq (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire two_wire_pkg::reg_req_type     req,
  output logic [31:0]                        rdata,
  input  wire two_wire_pkg::engine_event_type ev,
  input  wire logic                          rx_dma_dec,
  input  wire logic                          tx_dma_dec,
  output logic                               master_mode,
  output logic                               slave_mode,
  output logic                               ack_drive,
  output logic                               clock_stretch,
  output logic                               tx_byte_valid,
  output logic [7:0]                         tx_byte,
  output logic                               irq
);
  // ----------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------
  logic        wr_ctrl;
  logic        wr_set;
  logic        wr_clr;
  logic        wr_thr;
  logic        rd_status;
  logic        rd_rhr;
  logic [31:0] status;
  logic [31:0] mask;
  logic [7:0]  rx_byte;
  logic [15:0] rx_cnt;
  logic [15:0] rx_next;
  logic [15:0] tx_cnt;
  logic [15:0] tx_next;
  logic        done;
  logic        rx_full;
  logic        tx_empty;
  logic        slave_read_dir;
  logic        slave_addressed;
  logic        general_call_hit;
  logic        rx_overrun;
  logic        nack_flag;
  logic        arbitration_lost;
  logic        access_end;
  logic        rx_count_done;
  logic        tx_count_done;
  logic        master_cmd;

  assign wr_ctrl   = req.write && req.addr == two_wire_pkg::control_off;
  assign wr_set    = req.write && req.addr == two_wire_pkg::irq_set_off;
  assign wr_clr    = req.write && req.addr == two_wire_pkg::irq_clear_off;
  assign wr_thr    = req.write && req.addr == two_wire_pkg::tx_holding_off;
  assign rd_status = req.read && req.addr == two_wire_pkg::status_reg_off;
  assign rd_rhr    = req.read && req.addr == two_wire_pkg::rx_holding_off;
  assign master_cmd = wr_ctrl && req.wdata[two_wire_pkg::master_en_bit]
                      && !req.wdata[two_wire_pkg::master_dis_bit];

  // ----------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      master_mode <= 1'b0;
      slave_mode  <= 1'b0;
    end else if (wr_ctrl) begin
      // Disable wins over enable written in the same word
      if (req.wdata[two_wire_pkg::master_dis_bit]) begin
        master_mode <= 1'b0;
      end else if (req.wdata[two_wire_pkg::master_en_bit]) begin
        master_mode <= 1'b1;
        slave_mode  <= 1'b0;
      end
      if (req.wdata[two_wire_pkg::slave_dis_bit]) begin
        slave_mode <= 1'b0;
      end else if (req.wdata[two_wire_pkg::slave_en_bit]
                   && !req.wdata[two_wire_pkg::master_en_bit]) begin
        slave_mode  <= 1'b1;
        master_mode <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Transfer flags
  // ----------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done <= 1'b1;
    end else if (ev.nack_seen || ev.arb_lost) begin
      done <= 1'b1;
    end else if (master_mode) begin
      if (ev.stop_sent && ev.shifter_empty && tx_empty) begin
        done <= 1'b1;
      end else if (ev.frame_active) begin
        done <= 1'b0;
      end
    end else if (slave_mode) begin
      if (ev.stop_seen || ev.addr_miss) begin
        done <= 1'b1;
      end else if (ev.start_seen) begin
        done <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_full <= 1'b0;
      rx_byte <= 8'h00;
    end else if (ev.byte_rx) begin
      rx_full <= 1'b1;
      rx_byte <= ev.rx_data;
    end else if (rd_rhr) begin
      rx_full <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_empty      <= two_wire_pkg::status_reset[two_wire_pkg::tx_empty_bit];
      tx_byte       <= 8'h00;
      tx_byte_valid <= 1'b0;
    end else begin
      if (master_mode && (ev.shifter_load || ev.nack_seen)) begin
        tx_empty <= 1'b1;
      end else if (master_cmd) begin
        tx_empty <= 1'b1;
      end else if (slave_mode && (ev.byte_acked || ev.nack_seen)) begin
        tx_empty <= 1'b1;
      end else if (wr_thr) begin
        tx_empty <= 1'b0;
      end
      if (wr_thr) begin
        tx_byte       <= req.wdata[7:0];
        tx_byte_valid <= 1'b1;
      end else if (ev.shifter_load || ev.nack_seen) begin
        tx_byte_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Slave access flags
  // ----------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slave_addressed <= 1'b0;
      slave_read_dir  <= 1'b1;
      access_end      <= 1'b0;
    end else begin
      if (slave_mode && ev.addr_match) begin
        slave_addressed <= 1'b1;
        slave_read_dir  <= ev.addr_read;
      end else if (ev.nack_seen || ev.stop_seen) begin
        slave_addressed <= 1'b0;
      end
      if (slave_addressed && (ev.nack_seen || ev.stop_seen) && !ev.addr_match) begin
        access_end <= 1'b1;
      end else if (rd_status) begin
        access_end <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      general_call_hit <= 1'b0;
      rx_overrun       <= 1'b0;
      nack_flag        <= 1'b0;
      arbitration_lost <= 1'b0;
    end else begin
      if (slave_mode && ev.gcall_seen) begin
        general_call_hit <= 1'b1;
      end else if (rd_status) begin
        general_call_hit <= 1'b0;
      end
      if (master_mode && ev.byte_rx && rx_full && !rd_rhr) begin
        rx_overrun <= 1'b1;
      end else if (rd_status && done) begin
        rx_overrun <= 1'b0;
      end
      if (ev.nack_seen && (master_mode || (slave_mode && slave_read_dir))) begin
        nack_flag <= 1'b1;
      end else if (rd_status) begin
        nack_flag <= 1'b0;
      end
      if (master_mode && ev.arb_lost) begin
        arbitration_lost <= 1'b1;
      end else if (rd_status) begin
        arbitration_lost <= 1'b0;
      end
    end
  end

  // Stretch while the next character would find the holding register unserviced
  assign clock_stretch = slave_mode && slave_addressed && ev.char_due
                         && (slave_read_dir ? tx_empty && !nack_flag : rx_full);
  // Every data byte written to us is acknowledged
  assign ack_drive     = slave_mode && slave_addressed && !slave_read_dir;

  // ----------------------------------------------------------
  // DMA counters
  // ----------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_cnt        <= two_wire_pkg::dma_count_reset;
      rx_next       <= two_wire_pkg::dma_count_reset;
      rx_count_done <= two_wire_pkg::status_reset[two_wire_pkg::rx_cnt_done_bit];
    end else if (req.write && (req.addr == two_wire_pkg::rx_dma_cnt_off
                 || req.addr == two_wire_pkg::rx_dma_next_off)) begin
      if (req.addr == two_wire_pkg::rx_dma_cnt_off) begin
        rx_cnt <= req.wdata[15:0];
      end else begin
        rx_next <= req.wdata[15:0];
      end
      rx_count_done <= 1'b0;
    end else if (rx_dma_dec && rx_cnt != 16'h0000) begin
      rx_cnt <= rx_cnt - 16'h0001;
      if (rx_cnt == 16'h0001) begin
        rx_count_done <= master_mode;
        rx_cnt        <= rx_next;
        rx_next       <= 16'h0000;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_cnt        <= two_wire_pkg::dma_count_reset;
      tx_next       <= two_wire_pkg::dma_count_reset;
      tx_count_done <= two_wire_pkg::status_reset[two_wire_pkg::tx_cnt_done_bit];
    end else if (req.write && (req.addr == two_wire_pkg::tx_dma_cnt_off
                 || req.addr == two_wire_pkg::tx_dma_next_off)) begin
      if (req.addr == two_wire_pkg::tx_dma_cnt_off) begin
        tx_cnt <= req.wdata[15:0];
      end else begin
        tx_next <= req.wdata[15:0];
      end
      tx_count_done <= 1'b0;
    end else if (tx_dma_dec && tx_cnt != 16'h0000) begin
      tx_cnt <= tx_cnt - 16'h0001;
      if (tx_cnt == 16'h0001) begin
        tx_count_done <= master_mode;
        tx_cnt        <= tx_next;
        tx_next       <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------------------------
  always_comb begin
    status = 32'h00000000;
    status[two_wire_pkg::done_bit]        = done;
    status[two_wire_pkg::rx_full_bit]     = rx_full;
    status[two_wire_pkg::tx_empty_bit]    = tx_empty;
    status[two_wire_pkg::slave_read_bit]  = slave_read_dir;
    status[two_wire_pkg::addressed_bit]   = slave_addressed;
    status[two_wire_pkg::gcall_bit]       = general_call_hit;
    status[two_wire_pkg::overrun_bit]     = rx_overrun;
    status[two_wire_pkg::nack_bit]        = nack_flag;
    status[two_wire_pkg::arb_bit]         = arbitration_lost;
    status[two_wire_pkg::stretch_bit]     = clock_stretch;
    status[two_wire_pkg::access_end_bit]  = access_end;
    status[two_wire_pkg::rx_cnt_done_bit] = rx_count_done;
    status[two_wire_pkg::tx_cnt_done_bit] = tx_count_done;
    status[two_wire_pkg::rx_exh_bit]      = rx_cnt == 16'h0000 && rx_next == 16'h0000;
    status[two_wire_pkg::tx_exh_bit]      = tx_cnt == 16'h0000 && tx_next == 16'h0000;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask <= 32'h00000000;
    end else if (wr_set) begin
      mask <= mask | (req.wdata & two_wire_pkg::source_bits);
    end else if (wr_clr) begin
      mask <= mask & ~(req.wdata & two_wire_pkg::source_bits);
    end
  end

  assign irq = |(status & mask);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (req.read) begin
      unique case (req.addr)
        two_wire_pkg::status_reg_off:  rdata <= status;
        two_wire_pkg::irq_mask_off:    rdata <= mask;
        two_wire_pkg::rx_holding_off:  rdata <= {24'h000000, rx_byte};
        two_wire_pkg::rx_dma_cnt_off:  rdata <= {16'h0000, rx_cnt};
        two_wire_pkg::rx_dma_next_off: rdata <= {16'h0000, rx_next};
        two_wire_pkg::tx_dma_cnt_off:  rdata <= {16'h0000, tx_cnt};
        two_wire_pkg::tx_dma_next_off: rdata <= {16'h0000, tx_next};
        default:                       rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// File: two_wire_status_irq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_status_irq_sva (
  input wire logic                           clock,
  input wire logic                           rst,
  input wire two_wire_pkg::reg_req_type      req,
  input wire logic [31:0]                    rdata,
  input wire two_wire_pkg::engine_event_type ev,
  input wire logic                           master_mode,
  input wire logic                           slave_mode,
  input wire logic                           ack_drive,
  input wire logic                           irq
);
  // ----------------
  // Helpers
  // ----------------
  logic       rd_st;
  logic       wr_tx;
  logic       quiet;
  logic       en_seen;
  logic       rx_pend;
  logic [7:0] last_rx;
  assign rd_st = req.read && req.addr == two_wire_pkg::status_reg_off;
  assign wr_tx = req.write && req.addr == two_wire_pkg::tx_holding_off;
  // No event that would set a clear-on-read flag again
  assign quiet = !(ev.gcall_seen || ev.nack_seen || ev.arb_lost || ev.stop_seen);
  // Until some source is enabled the interrupt has nothing to pass
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_seen <= 1'b0;
    end else if (req.write && req.addr == two_wire_pkg::irq_set_off
                 && |(req.wdata & two_wire_pkg::source_bits)) begin
      en_seen <= 1'b1;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_pend <= 1'b0;
      last_rx <= 8'h00;
    end else if (ev.byte_rx) begin
      rx_pend <= 1'b1;
      last_rx <= ev.rx_data;
    end else if (req.read && req.addr == two_wire_pkg::rx_holding_off) begin
      rx_pend <= 1'b0;
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_mask_no_reserved: assert property (
    req.read && req.addr == two_wire_pkg::irq_mask_off |=> (rdata & 32'hffff0008) == 32'h0)
    else $error("mask register shows a bit that holds no source");
  a_rx_byte_value: assert property (
    req.read && req.addr == two_wire_pkg::rx_holding_off && !ev.byte_rx
    |=> rdata == {24'h0, last_rx})
    else $error("receive holding read differs from last byte");
  a_rx_full_flag: assert property (rd_st |=> rdata[1] == $past(rx_pend))
    else $error("receive ready flag wrong");
  a_clear_on_read: assert property (
    rd_st && quiet ##1 rd_st && quiet |=> (rdata & 32'h00000320) == 32'h0)
    else $error("clear-on-read flag survived a status read");
  a_irq_quiet: assert property (!en_seen |-> !irq)
    else $error("interrupt with no source enabled");
  a_irq_disable: assert property (
    req.write && req.addr == two_wire_pkg::irq_clear_off && req.wdata == 32'hffffffff
    |=> !irq)
    else $error("interrupt after disabling every source");
  a_ack_slave_write: assert property (
    slave_mode && ev.addr_match && !ev.addr_read |=> ack_drive)
    else $error("slave write not acknowledged");
  a_done_in_frame: assert property (
    master_mode && ev.frame_active && !ev.stop_sent && !ev.nack_seen && !ev.arb_lost ##1
    rd_st && ev.frame_active && !ev.stop_sent && !ev.nack_seen && !ev.arb_lost
    |=> !rdata[0])
    else $error("transfer done high inside a frame");
  a_tx_write_clears: assert property (
    master_mode && wr_tx && !ev.shifter_load && !ev.nack_seen ##1
    !req.write && !ev.shifter_load && !ev.nack_seen ##1
    rd_st && !ev.shifter_load && !ev.nack_seen |=> !rdata[2])
    else $error("transmit ready high after holding write");
  c_nack_read: cover property (rd_st ##1 rdata[8]);
  c_rx_read: cover property (rx_pend && req.read && req.addr == two_wire_pkg::rx_holding_off);
  c_irq_up: cover property (irq);
endmodule
bind two_wire_status_irq two_wire_status_irq_sva chk (
  .clock       (clock),
  .rst         (rst),
  .req         (req),
  .rdata       (rdata),
  .ev          (ev),
  .master_mode (master_mode),
  .slave_mode  (slave_mode),
  .ack_drive   (ack_drive),
  .irq         (irq)
);
`default_nettype wire

// File: two_wire_status_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module two_wire_status_irq_tb;
  localparam logic [7:0] st = two_wire_pkg::status_reg_off;
  localparam logic [7:0] ie = two_wire_pkg::irq_set_off;
  localparam logic [7:0] id = two_wire_pkg::irq_clear_off;
  localparam logic [7:0] rh = two_wire_pkg::rx_holding_off;
  localparam logic [7:0] th = two_wire_pkg::tx_holding_off;
  logic                           clock = 1'b0;
  logic                           rst = 1'b1;
  two_wire_pkg::reg_req_type      req = '0;
  two_wire_pkg::engine_event_type stim = '0;
  two_wire_pkg::engine_event_type ev;
  logic                           rx_dma_dec = 1'b0;
  logic                           tx_dma_dec = 1'b0;
  logic [31:0]                    rdata;
  logic [31:0]                    d;
  logic [31:0]                    d0;
  logic                           master_mode;
  logic                           slave_mode;
  logic                           ack_drive;
  logic                           clock_stretch;
  logic                           irq;
  logic                           tx_byte_valid;
  logic [7:0]                     tx_byte;
  int                             n_errors = 0;
  int                             tests_run = 0;
  always #4 clock = ~clock;
  two_wire_bus_peer peer (.clock(clock), .rst(rst), .stim(stim), .ev(ev));
  two_wire_status_irq uut (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .ev(ev),
    .rx_dma_dec(rx_dma_dec), .tx_dma_dec(tx_dma_dec), .master_mode(master_mode),
    .slave_mode(slave_mode), .ack_drive(ack_drive), .clock_stretch(clock_stretch),
    .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte), .irq(irq));
  // ----------------
  // Access tasks
  // ----------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    req <= '{addr: a, wdata: v, write: 1'b1, read: 1'b0};
    @(posedge clock);
    req.write <= 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
    @(posedge clock);
    req.read <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  // Two reads back to back: d0 then d
  task automatic rr(input logic [7:0] a);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
    @(posedge clock);
    @(negedge clock);
    d0 = rdata;
    @(posedge clock);
    req.read <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  // One-cycle event p, then levels l stay on
  task automatic fire(input two_wire_pkg::engine_event_type p,
                      input two_wire_pkg::engine_event_type l);
    @(posedge clock);
    stim <= two_wire_pkg::engine_event_type'(p | l);
    @(posedge clock);
    stim <= l;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(st);
    `CHK("status reset", 32'h0000f009, d)
    rd(two_wire_pkg::irq_mask_off);
    `CHK("mask reset", 32'h0, d)
    rd(8'h38);
    `CHK("unmapped read", 32'h0, d)
    $display("test reset done");
    wr(ie, 32'hffffffff);
    rd(two_wire_pkg::irq_mask_off);
    `CHK("mask all", 32'h0000fff7, d)
    `CHK("irq on", 1'b1, irq)
    wr(id, 32'h00000001);
    wr(ie, 32'h0);
    rd(two_wire_pkg::irq_mask_off);
    `CHK("mask one off", 32'h0000fff6, d)
    wr(id, 32'hffffffff);
    `CHK("irq off", 1'b0, irq)
    wr(ie, 32'h00000002);
    fire('{byte_rx: 1'b1, rx_data: 8'ha5, default: 0}, '0);
    `CHK("irq rx", 1'b1, irq)
    rd(st);
    `CHK("rx full", 32'h2, d & 32'h2)
    rd(rh);
    `CHK("rx byte", 32'h000000a5, d)
    rd(st);
    `CHK("rx emptied", 32'h0, d & 32'h2)
    `CHK("irq rx off", 1'b0, irq)
    $display("test irq and receive done");
    wr(two_wire_pkg::control_off, 32'h4);
    `CHK("master mode", 2'b10, {master_mode, slave_mode})
    wr(th, 32'h3c);
    `CHK("tx byte", 9'h13c, {tx_byte_valid, tx_byte})
    rd(st);
    `CHK("tx write", 32'h0, d & 32'h4)
    wr(two_wire_pkg::control_off, 32'h4);
    rd(st);
    `CHK("tx on enable", 32'h4, d & 32'h4)
    wr(th, 32'h77);
    fire('{nack_seen: 1'b1, default: 0}, '0);
    rr(st);
    `CHK("nack set", 32'h105, d0 & 32'h105)
    `CHK("nack read", 32'h0, d & 32'h100)
    `CHK("tx byte dropped", 1'b0, tx_byte_valid)
    fire('{arb_lost: 1'b1, default: 0}, '0);
    rr(st);
    `CHK("arb set", 32'h201, d0 & 32'h201)
    `CHK("arb read", 32'h0, d & 32'h200)
    fire('{byte_rx: 1'b1, rx_data: 8'h11, default: 0}, '0);
    fire('{byte_rx: 1'b1, rx_data: 8'h22, default: 0}, '0);
    rr(st);
    `CHK("overrun set", 32'h41, d0 & 32'h41)
    `CHK("overrun read", 32'h0, d & 32'h40)
    rd(rh);
    `CHK("last byte", 32'h00000022, d)
    fire('0, '{frame_active: 1'b1, default: 0});
    wr(th, 32'h11);
    rd(st);
    `CHK("done in frame", 32'h0, d & 32'h1)
    fire('{stop_sent: 1'b1, default: 0}, '{shifter_empty: 1'b1, default: 0});
    rd(st);
    `CHK("done holding full", 32'h0, d & 32'h1)
    fire('{shifter_load: 1'b1, default: 0}, '{shifter_empty: 1'b1, default: 0});
    fire('{stop_sent: 1'b1, default: 0}, '{shifter_empty: 1'b1, default: 0});
    rd(st);
    `CHK("done after stop", 32'h1, d & 32'h1)
    $display("test master done");
    for (int k = 0; k < 2; k++) begin
      wr(k ? two_wire_pkg::tx_dma_cnt_off : two_wire_pkg::rx_dma_cnt_off, 32'h2);
      rd(st);
      `CHK("dma loaded", 32'h0, d & (32'h5000 << k))
      repeat (2) begin
        @(posedge clock);
        rx_dma_dec <= (k == 0);
        tx_dma_dec <= (k == 1);
        @(posedge clock);
        rx_dma_dec <= 1'b0;
        tx_dma_dec <= 1'b0;
      end
      rd(st);
      `CHK("dma drained", 32'h5000 << k, d & (32'h5000 << k))
    end
    $display("test dma done");
    wr(two_wire_pkg::control_off, 32'h18);
    `CHK("slave mode", 2'b01, {master_mode, slave_mode})
    fire('{start_seen: 1'b1, default: 0}, '0);
    rd(st);
    `CHK("slave start", 32'h0, d & 32'h1)
    fire('{addr_match: 1'b1, addr_read: 1'b1, default: 0}, '0);
    rd(st);
    `CHK("addressed read", 32'h18, d & 32'h18)
    wr(th, 32'h66);
    rd(st);
    `CHK("slave tx pending", 32'h0, d & 32'h4)
    fire('{shifter_load: 1'b1, byte_acked: 1'b1, default: 0}, '0);
    rd(st);
    `CHK("slave tx sent", 32'h4, d & 32'h4)
    fire('{nack_seen: 1'b1, default: 0}, '0);
    rr(st);
    `CHK("slave nack", 32'h900, d0 & 32'h910)
    `CHK("slave nack read", 32'h0, d & 32'h900)
    // Received byte left unread while the next character is due stretches the clock
    fire('{start_seen: 1'b1, default: 0}, '0);
    fire('{addr_match: 1'b1, default: 0}, '0);
    `CHK("ack on write", 1'b1, ack_drive)
    rd(st);
    `CHK("addressed write", 32'h10, d & 32'h18)
    fire('{byte_rx: 1'b1, rx_data: 8'h5c, default: 0}, '0);
    fire('0, '{char_due: 1'b1, default: 0});
    `CHK("stretch on", 1'b1, clock_stretch)
    rd(st);
    `CHK("stretch flag", 32'h400, d & 32'h400)
    rd(rh);
    `CHK("stretch off", 1'b0, clock_stretch)
    fire('{stop_seen: 1'b1, default: 0}, '0);
    rr(st);
    `CHK("slave stop", 32'h801, d0 & 32'h811)
    `CHK("access end read", 32'h0, d & 32'h800)
    fire('{gcall_seen: 1'b1, default: 0}, '0);
    rr(st);
    `CHK("gcall set", 32'h20, d0 & 32'h20)
    `CHK("gcall read", 32'h0, d & 32'h20)
    fire('{start_seen: 1'b1, default: 0}, '0);
    fire('{addr_miss: 1'b1, default: 0}, '0);
    rd(st);
    `CHK("foreign address", 32'h1, d & 32'h1)
    $display("test slave done");
    conclude();
  end
endmodule
`default_nettype wire
